// file: asrc_host.sv
`timescale 1ns/100ps
module asrc_host (
	// bench control
	input wire logic       run,
	input wire logic       edge_inv,
	input wire logic       alt_fs,
	input wire logic [4:0] delay,
	// serial link
	output logic           link_clock,
	output logic           frame_sync,
	output logic           internal_frame_sync,
	output logic           primary_serial_in,
	output logic           secondary_serial_in
);
	int p;
	int k;

	// tdm, 16-bit slots; slot s word carries s in its low nibble
	function automatic logic tx_bit(input logic [11:0] h, input int k);
		logic [15:0] w;
		w = {h, 4'(k / 16)};
		return w[15 - k % 16];
	endfunction

	// clock stops low between bursts
	initial begin
		{link_clock, frame_sync, internal_frame_sync} = '0;
		{primary_serial_in, secondary_serial_in} = 2'b01;
		p = 159;
		#17;
		forever begin
			#40;
			if (run || link_clock) link_clock = ~link_clock;
		end
	end

	// drive on the edge opposite the capture edge
	always @(link_clock) begin
		if (link_clock == edge_inv) begin
			if (!run) p = 159;
			else p = (p == 159) ? 0 : p + 1;
			k = p - delay;
			frame_sync = !alt_fs && p == 0;
			internal_frame_sync = alt_fs && p == 0;
			// msb shifted by delay, idle bits toggle
			primary_serial_in = (k >= 0 && k < 128) ? tx_bit(12'ha5c, k) : p[0];
			secondary_serial_in = (k >= 0 && k < 128) ? tx_bit(12'h3b6, k) : !p[0];
		end
	end
endmodule

// file: asrc_pkg.sv
package asrc_pkg;

	// register indices; byte address is four times the index
	localparam logic [5:0] REG_STATUS      = 6'h1e;
	localparam logic [5:0] REG_PORT_CTRL   = 6'h1f;
	localparam logic [5:0] REG_FRAME_CFG   = 6'h26;
	localparam logic [5:0] REG_PIN_SEL     = 6'h27;
	localparam logic [5:0] REG_CH_CFG_BASE = 6'h28;

	localparam int NUM_CH = 8;

	// rx_frame_config fields
	localparam int FC_EDGE_INV = 7;
	localparam int FC_INT_FS   = 6;
	localparam int FC_INT_BCLK = 5;
	localparam int FC_DELAY_HI = 4;

	// per-channel config fields
	localparam int CH_ENABLE  = 5;
	localparam int CH_SLOT_HI = 4;

	// port control fields
	localparam int PC_FMT_HI   = 1;
	localparam int PC_POLARITY = 2;
	localparam int PC_CTRL     = 3;
	localparam int PC_WL_HI    = 5;
	localparam int PC_WL_LO    = 4;

	localparam logic [7:0] FRAME_CFG_RST = 8'h00;
	localparam logic [7:0] PIN_SEL_RST   = 8'h00;
	localparam logic [7:0] PORT_CTRL_RST = 8'h00;
	localparam logic [7:0] CH_CFG_MASK   = 8'h3f;
	localparam logic [7:0] PC_MASK       = 8'h3f;
	localparam logic [7:0][7:0] CH_CFG_RST = {8'h07, 8'h06, 8'h05, 8'h04,
		8'h03, 8'h02, 8'h21, 8'h20};

	// slot counter saturates here: no format has more slots
	localparam logic [5:0] SLOT_LIMIT = 6'h20;
	localparam logic [5:0] I2S_LEAD  = 6'h01;

	typedef enum logic [1:0] {
		ASRC_FMT_TDM = 2'b00,
		ASRC_FMT_I2S = 2'b01,
		ASRC_FMT_LJ  = 2'b10
	} asrc_format_t;

	typedef enum logic [1:0] {
		ASRC_LINK_IDLE  = 2'b00,
		ASRC_LINK_DELAY = 2'b01,
		ASRC_LINK_RUN   = 2'b10
	} asrc_link_state_t;

	typedef struct packed {
		logic            edge_inv;
		logic            int_fs;
		logic [4:0]      delay;
		logic [7:0]      pin_sel;
		logic [7:0]      ch_en;
		logic [7:0][4:0] ch_slot;
		logic [1:0]      format;
		logic            polarity;
		logic [1:0]      word_len;
	} asrc_cfg_t;

endpackage

// file: asrc_rx.sv
`timescale 1ns/100ps
// Summary of operation
// - edge bit picks default or inverted capture edge
// - controller mode: internal or external frame sync
// - controller mode: internal or external bit clock
// - slot-0 MSB delayed by 0..31 bit clocks
// - offset and edge apply to both pins
// - offset applies to left/right or TDM slot 0
// - pin-select bit n-1 picks channel n pin
// - reset: default edge, external clocks, primary pins
// - five-bit slot number per channel, halves in I2S/LJ
// - channel enable gates data to its DAC channel
module asrc_rx (
	// system
	input  wire logic                   clock,
	input  wire logic                   resetn,
	// wishbone slave
	input  wire logic [7:0]             wb_adr_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic      [31:0]            wb_dat_o,
	input  wire logic                   wb_we_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_cyc_i,
	output logic                        wb_ack_o,
	// serial link, all on the selected bit clock
	input  wire logic                   link_clock,
	input  wire logic                   frame_sync,
	input  wire logic                   internal_frame_sync,
	input  wire logic                   primary_serial_in,
	input  wire logic                   secondary_serial_in,
	// bit clock mux steering
	output logic                        bit_clock_internal_sel,
	// dac side
	output logic [7:0][31:0]            dac_channel_data,
	output logic [7:0]                  dac_channel_valid,
	output logic                        dac_frame_strobe
);

	function automatic logic [4:0] last_bit(input logic [1:0] wl);
		unique case (wl)
			2'b00: last_bit = 5'h0f;
			2'b01: last_bit = 5'h13;
			2'b10: last_bit = 5'h17;
			2'b11: last_bit = 5'h1f;
		endcase
	endfunction

	function automatic logic slot_match(input logic [1:0] fmt, input logic half,
		input logic [5:0] slot, input logic [4:0] sel);
		if (fmt == asrc_pkg::ASRC_FMT_I2S || fmt == asrc_pkg::ASRC_FMT_LJ)
			slot_match = (sel[4] == half) && (slot[5:4] == 2'b00)
				&& (sel[3:0] == slot[3:0]);
		else
			slot_match = ({1'b0, sel} == slot);
	endfunction

	// ---------------- system domain ----------------
	typedef struct packed {
		logic [7:0]       frame_cfg;
		logic [7:0]       pin_sel;
		logic [7:0]       port_ctrl;
		logic [7:0][7:0]  ch_cfg;
		logic             ack;
		logic [7:0]       rdata;
		asrc_pkg::asrc_cfg_t snap;
		logic             req;
		logic             ack_s1;
		logic             ack_s2;
		logic             pub_s1;
		logic             pub_s2;
		logic             pub_s3;
		logic [7:0][31:0] data;
		logic [7:0]       valid;
		logic             strobe;
		logic [6:0]       frame_cnt;
		logic             bclk_int;
	} asrc_sys_t;

	typedef struct packed {
		asrc_pkg::asrc_cfg_t cfg;
		logic             req_s1;
		logic             req_s2;
		logic             req_s3;
		asrc_pkg::asrc_link_state_t state;
		logic             fs_prev;
		logic             half;
		logic             framed;
		logic [5:0]       dly;
		logic [4:0]       bit_cnt;
		logic [5:0]       slot_cnt;
		logic [31:0]      sh_pri;
		logic [31:0]      sh_sec;
		logic [7:0][31:0] word;
		logic [7:0][31:0] pub_data;
		logic [7:0]       pub_valid;
		logic             pub_tgl;
	} asrc_link_t;

	asrc_sys_t            r;
	asrc_sys_t            next_r;
	asrc_link_t           l;
	asrc_link_t           next_l;
	asrc_pkg::asrc_cfg_t  cfg_now;
	logic                 neg_pri;
	logic                 neg_sec;
	logic                 neg_fs;

	always_comb begin
		logic [5:0] idx;
		logic       busy;
		idx = wb_adr_i[7:2];
		busy = 1'b0;
		next_r = r;
		cfg_now.edge_inv = r.frame_cfg[asrc_pkg::FC_EDGE_INV];
		cfg_now.int_fs = r.port_ctrl[asrc_pkg::PC_CTRL]
			& r.frame_cfg[asrc_pkg::FC_INT_FS];
		cfg_now.delay = r.frame_cfg[asrc_pkg::FC_DELAY_HI:0];
		cfg_now.pin_sel = r.pin_sel;
		for (int i = 0; i < asrc_pkg::NUM_CH; i++) begin
			cfg_now.ch_en[i] = r.ch_cfg[i][asrc_pkg::CH_ENABLE];
			cfg_now.ch_slot[i] = r.ch_cfg[i][asrc_pkg::CH_SLOT_HI:0];
		end
		cfg_now.format = r.port_ctrl[asrc_pkg::PC_FMT_HI:0];
		cfg_now.polarity = r.port_ctrl[asrc_pkg::PC_POLARITY];
		cfg_now.word_len = r.port_ctrl[asrc_pkg::PC_WL_HI:asrc_pkg::PC_WL_LO];
		next_r.bclk_int = r.port_ctrl[asrc_pkg::PC_CTRL]
			& r.frame_cfg[asrc_pkg::FC_INT_BCLK];

		// single-cycle ack, dropped the cycle after
		next_r.ack = wb_cyc_i & wb_stb_i & ~r.ack;
		if (next_r.ack) begin
			next_r.rdata = 8'h00;
			if (idx == asrc_pkg::REG_STATUS)
				next_r.rdata = {r.frame_cnt, r.req ^ r.ack_s2};
			else if (idx == asrc_pkg::REG_PORT_CTRL)
				next_r.rdata = r.port_ctrl;
			else if (idx == asrc_pkg::REG_FRAME_CFG)
				next_r.rdata = r.frame_cfg;
			else if (idx == asrc_pkg::REG_PIN_SEL)
				next_r.rdata = r.pin_sel;
			else if (idx[5:3] == asrc_pkg::REG_CH_CFG_BASE[5:3])
				next_r.rdata = r.ch_cfg[idx[2:0]];
			if (wb_we_i && wb_sel_i[0]) begin
				if (idx == asrc_pkg::REG_PORT_CTRL)
					next_r.port_ctrl = wb_dat_i[7:0] & asrc_pkg::PC_MASK;
				else if (idx == asrc_pkg::REG_FRAME_CFG)
					next_r.frame_cfg = wb_dat_i[7:0];
				else if (idx == asrc_pkg::REG_PIN_SEL)
					next_r.pin_sel = wb_dat_i[7:0];
				else if (idx[5:3] == asrc_pkg::REG_CH_CFG_BASE[5:3])
					next_r.ch_cfg[idx[2:0]] = wb_dat_i[7:0] & asrc_pkg::CH_CFG_MASK;
			end
		end

		// config crossing: snapshot held still until the link acknowledges
		next_r.ack_s1 = l.req_s3;
		next_r.ack_s2 = r.ack_s1;
		busy = r.req ^ r.ack_s2;
		if (!busy && (cfg_now != r.snap)) begin
			next_r.snap = cfg_now;
			next_r.req = ~r.req;
		end

		// frame crossing: link buffer is stable for a whole frame after the toggle
		next_r.pub_s1 = l.pub_tgl;
		next_r.pub_s2 = r.pub_s1;
		next_r.pub_s3 = r.pub_s2;
		next_r.strobe = r.pub_s2 ^ r.pub_s3;
		if (next_r.strobe) begin
			next_r.data = l.pub_data;
			next_r.valid = l.pub_valid;
			next_r.frame_cnt = r.frame_cnt + 7'h01;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			r <= '0;
			r.frame_cfg <= asrc_pkg::FRAME_CFG_RST;
			r.pin_sel <= asrc_pkg::PIN_SEL_RST;
			r.port_ctrl <= asrc_pkg::PORT_CTRL_RST;
			r.ch_cfg <= asrc_pkg::CH_CFG_RST;
		end else begin
			r <= next_r;
		end
	end

	assign wb_ack_o = r.ack;
	assign wb_dat_o = {24'h000000, r.rdata};
	assign bit_clock_internal_sel = r.bclk_int;
	assign dac_channel_data = r.data;
	assign dac_channel_valid = r.valid;
	assign dac_frame_strobe = r.strobe;

	// ---------------- link domain ----------------
	// falling-edge samples, used when the capture edge is the falling one
	always_ff @(negedge link_clock or negedge resetn) begin
		if (!resetn) begin
			neg_pri <= 1'b0;
			neg_sec <= 1'b0;
			neg_fs <= 1'b0;
		end else begin
			neg_pri <= primary_serial_in;
			neg_sec <= secondary_serial_in;
			neg_fs <= l.cfg.int_fs ? internal_frame_sync : frame_sync;
		end
	end

	always_comb begin
		logic        on_fall;
		logic        bit_pri;
		logic        bit_sec;
		logic        fs;
		logic        fs_edge;
		logic        new_half;
		logic        take;
		logic [5:0]  total;
		logic [31:0] mask;
		logic [31:0] w_pri;
		logic [31:0] w_sec;
		next_l = l;
		take = 1'b0;
		new_half = 1'b0;
		fs_edge = 1'b0;
		on_fall = 1'b0;
		bit_pri = 1'b0;
		bit_sec = 1'b0;
		fs = 1'b0;
		total = 6'h00;
		w_pri = '0;
		w_sec = '0;
		mask = 32'hffffffff >> (5'h1f - last_bit(l.cfg.word_len));

		next_l.req_s1 = r.req;
		next_l.req_s2 = l.req_s1;
		next_l.req_s3 = l.req_s2;
		if (l.req_s2 != l.req_s3)
			next_l.cfg = r.snap;

		on_fall = l.cfg.polarity ^ l.cfg.edge_inv;
		bit_pri = on_fall ? neg_pri : primary_serial_in;
		bit_sec = on_fall ? neg_sec : secondary_serial_in;
		fs = on_fall ? neg_fs : (l.cfg.int_fs ? internal_frame_sync : frame_sync);
		next_l.fs_prev = fs;

		if (l.cfg.format == asrc_pkg::ASRC_FMT_I2S) begin
			fs_edge = fs ^ l.fs_prev;
			new_half = fs;
		end else if (l.cfg.format == asrc_pkg::ASRC_FMT_LJ) begin
			fs_edge = fs ^ l.fs_prev;
			new_half = ~fs;
		end else begin
			fs_edge = fs & ~l.fs_prev;
		end
		total = {1'b0, l.cfg.delay}
			+ ((l.cfg.format == asrc_pkg::ASRC_FMT_I2S) ? asrc_pkg::I2S_LEAD : 6'h00);

		if (fs_edge) begin
			// every half restarts at slot 0, so the offset hits both halves
			next_l.half = new_half;
			next_l.bit_cnt = '0;
			next_l.slot_cnt = '0;
			if (!new_half) begin
				if (l.framed) begin
					next_l.pub_data = l.word;
					next_l.pub_valid = l.cfg.ch_en;
					next_l.pub_tgl = ~l.pub_tgl;
				end
				next_l.framed = 1'b1;
			end
			if (total == 6'h00) begin
				next_l.state = asrc_pkg::ASRC_LINK_RUN;
				take = 1'b1;
			end else begin
				next_l.state = asrc_pkg::ASRC_LINK_DELAY;
				next_l.dly = total - 6'h01;
			end
		end else begin
			unique case (l.state)
				asrc_pkg::ASRC_LINK_IDLE: begin
				end
				asrc_pkg::ASRC_LINK_DELAY: begin
					if (l.dly == 6'h00) begin
						next_l.state = asrc_pkg::ASRC_LINK_RUN;
						take = 1'b1;
					end else begin
						next_l.dly = l.dly - 6'h01;
					end
				end
				asrc_pkg::ASRC_LINK_RUN: take = 1'b1;
				default: next_l.state = asrc_pkg::ASRC_LINK_IDLE;
			endcase
		end

		if (take) begin
			w_pri = {l.sh_pri[30:0], bit_pri} & mask;
			w_sec = {l.sh_sec[30:0], bit_sec} & mask;
			next_l.sh_pri = {l.sh_pri[30:0], bit_pri};
			next_l.sh_sec = {l.sh_sec[30:0], bit_sec};
			if (next_l.bit_cnt == last_bit(l.cfg.word_len)) begin
				for (int i = 0; i < asrc_pkg::NUM_CH; i++) begin
					if (l.cfg.ch_en[i] && slot_match(l.cfg.format, next_l.half,
						next_l.slot_cnt, l.cfg.ch_slot[i]))
						next_l.word[i] = l.cfg.pin_sel[i] ? w_sec : w_pri;
				end
				next_l.bit_cnt = '0;
				if (next_l.slot_cnt != asrc_pkg::SLOT_LIMIT)
					next_l.slot_cnt = next_l.slot_cnt + 6'h01;
			end else begin
				next_l.bit_cnt = next_l.bit_cnt + 5'h01;
			end
		end
	end

	always_ff @(posedge link_clock or negedge resetn) begin
		if (!resetn) begin
			l <= '0;
			l.state <= asrc_pkg::ASRC_LINK_IDLE;
		end else begin
			l <= next_l;
		end
	end

endmodule

// file: asrc_rx_checker.sv
`timescale 1ns/100ps
module asrc_rx_checker (
	// system
	input wire logic                   clock,
	input wire logic                   resetn,
	// register bus
	input wire logic [7:0]             wb_adr_i,
	input wire logic [31:0]            wb_dat_i,
	input wire logic [31:0]            wb_dat_o,
	input wire logic                   wb_we_i,
	input wire logic [3:0]             wb_sel_i,
	input wire logic                   wb_stb_i,
	input wire logic                   wb_cyc_i,
	input wire logic                   wb_ack_o,
	// outputs toward the mux and dac
	input wire logic                   bit_clock_internal_sel,
	input wire logic [7:0][31:0]       dac_channel_data,
	input wire logic [7:0]             dac_channel_valid,
	input wire logic                   dac_frame_strobe
);
	logic [7:0] fc_sh;
	logic [7:0] pin_sh;
	logic [7:0] pc_sh;
	logic       wr;
	logic       rd;

	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);

	assign wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
	assign rd = wb_ack_o && !wb_we_i;

	// mirror of written config, updated at the edge that takes the write
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fc_sh  <= 8'h00;
			pin_sh <= 8'h00;
			pc_sh  <= 8'h00;
		end else if (wr) begin
			if (wb_adr_i[7:2] == asrc_pkg::REG_FRAME_CFG) fc_sh <= wb_dat_i[7:0];
			if (wb_adr_i[7:2] == asrc_pkg::REG_PIN_SEL) pin_sh <= wb_dat_i[7:0];
			if (wb_adr_i[7:2] == asrc_pkg::REG_PORT_CTRL) pc_sh <= wb_dat_i[7:0];
		end
	end

	property p_ack_next;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack missing");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_pin_read;
		rd && wb_adr_i[7:2] == asrc_pkg::REG_PIN_SEL |-> wb_dat_o == {24'h0, pin_sh};
	endproperty
	a_pin_read: assert property (p_pin_read) else $error("pin select readback");
	property p_fc_read;
		rd && wb_adr_i[7:2] == asrc_pkg::REG_FRAME_CFG |-> wb_dat_o == {24'h0, fc_sh};
	endproperty
	a_fc_read: assert property (p_fc_read) else $error("frame config readback");
	property p_upper_zero;
		wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
	property p_unmapped;
		rd && wb_adr_i[7:2] < asrc_pkg::REG_STATUS |-> wb_dat_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_bclk_sel;
		!wb_cyc_i [*3] |-> bit_clock_internal_sel == (fc_sh[5] & pc_sh[3]);
	endproperty
	a_bclk_sel: assert property (p_bclk_sel) else $error("bit clock select");
	property p_strobe;
		dac_frame_strobe |=> !dac_frame_strobe;
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe too long");
	property p_hold;
		!dac_frame_strobe |-> $stable(dac_channel_data) && $stable(dac_channel_valid);
	endproperty
	a_hold: assert property (p_hold) else $error("dac output moved");
endmodule

bind asrc_rx asrc_rx_checker asrc_rx_checker_inst (.*);

// file: audio_serial_rx_config_test.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
	$display("wrong value at %0t: %h not %h", $time, (got), (exp)); end end
module audio_serial_rx_config_test;
	logic                   clock, resetn, wb_we_i, wb_stb_i, wb_cyc_i, wb_ack_o;
	logic [7:0]             wb_adr_i, rd;
	logic [31:0]            wb_dat_i, wb_dat_o;
	logic [3:0]             wb_sel_i;
	logic                   link_clock, frame_sync, internal_frame_sync;
	logic                   primary_serial_in, secondary_serial_in, bit_clock_internal_sel;
	logic [7:0][31:0]       dac_channel_data;
	logic [7:0]             dac_channel_valid;
	logic                   dac_frame_strobe, run, edge_inv, alt_fs;
	logic [4:0]             delay;
	int                     error_cnt, checks;
	// per test: frame config, pin select, port control, internal frame sync
	logic [7:0]             fcs [4] = '{8'h00, 8'h9f, 8'h01, 8'h7e};
	logic [7:0]             pins [4] = '{8'h00, 8'ha5, 8'h5a, 8'hff};
	logic [7:0]             pcs [4] = '{8'h00, 8'h00, 8'h00, 8'h08};
	logic [3:0]             alts = 4'b1000;

	asrc_rx asrc_rx_inst (.*);
	asrc_host asrc_host_inst (.*);

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task automatic wb_rw(input logic [7:0] a, input logic w, input logic [7:0] d);
		int n;
		@(posedge clock);
		wb_adr_i <= a;
		wb_we_i <= w;
		wb_dat_i <= {24'h0, d};
		wb_sel_i <= 4'h1;
		{wb_cyc_i, wb_stb_i} <= 2'b11;
		n = 0;
		// request stands until the edge that sees ack; data taken and released there
		do begin
			@(posedge clock);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 40);
		rd = wb_dat_o[7:0];
		if (n >= 40) error_cnt++;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask

	task close_out;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#400000;
		error_cnt++;
		close_out();
	end

	initial begin
		{resetn, wb_we_i, wb_stb_i, wb_cyc_i, run, edge_inv, alt_fs, delay} = '0;
		{wb_adr_i, wb_dat_i, wb_sel_i} = '0;
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		wb_rw(8'h98, 1'b0, 8'h00);
		`CHK(rd, 8'h00)
		wb_rw(8'h9c, 1'b0, 8'h00);
		`CHK(rd, 8'h00)
		wb_rw(8'ha4, 1'b0, 8'h00);
		`CHK(rd, 8'h21)
		wb_rw(8'h00, 1'b1, 8'hff);
		wb_rw(8'h00, 1'b0, 8'h00);
		`CHK(rd, 8'h00)
		$display("test reset done");
		for (int i = 0; i < 8; i++) wb_rw(8'ha0 + 8'(4 * i), 1'b1, 8'h20 | 8'(i));
		for (int c = 0; c < 4; c++) begin
			wb_rw(8'h7c, 1'b1, pcs[c]);
			wb_rw(8'h98, 1'b1, fcs[c]);
			wb_rw(8'h9c, 1'b1, pins[c]);
			wb_rw(8'h98, 1'b0, 8'h00);
			`CHK(rd, fcs[c])
			edge_inv <= fcs[c][7];
			delay <= fcs[c][4:0];
			alt_fs <= alts[c];
			run <= 1'b1;
			// four frames: the second and third are published with the new setup
			repeat (640) @(posedge link_clock);
			@(posedge clock);
			run <= 1'b0;
			repeat (20) @(posedge clock);
			`CHK(bit_clock_internal_sel, fcs[c][5] & pcs[c][3])
			`CHK(dac_channel_valid, 8'hff)
			for (int i = 0; i < 8; i++) `CHK(dac_channel_data[i], {16'h0, pins[c][i] ? 12'h3b6 : 12'ha5c, 4'(i)})
			$display("test %0d done", c);
		end
		close_out();
	end
endmodule
